// file: hw/pgr_pkg.sv
// shared constants and types for the power-good mask and i/o rail control block
`default_nettype none

package pgr_pkg;

   // register offsets on the i2c register map
   localparam logic [7:0] OFS_PG_MASK_UPPER = 8'h19;
   localparam logic [7:0] OFS_IO_RAIL_CTRL = 8'h30;

   // reset values
   localparam logic [7:0] RST_PG_MASK_UPPER = 8'h00;
   localparam logic [7:0] RST_IO_RAIL_CTRL = 8'h1a;
   localparam logic [3:0] RST_MASK_BITS = 4'h0;
   localparam logic RST_DECAY_EN = 1'b0;
   localparam logic [1:0] RST_MODE = 2'h2;

   // mask register field positions
   localparam int POS_MASK_SWITCHED_1V8 = 0;
   localparam int POS_MASK_SWITCHED_3V3 = 1;
   localparam int POS_MASK_MEMORY_RAIL = 2;
   localparam int POS_MASK_DUAL_LOW_RAIL = 3;
   localparam logic [3:0] MASK_RSV_VALUE = 4'h0;

   // i/o rail control field positions and fixed reserved contents
   localparam int POS_IO_MODE_LO = 0;
   localparam int POS_IO_MODE_HI = 1;
   localparam int POS_IO_DECAY_EN = 6;
   localparam logic IO_RSV7_VALUE = 1'b0;
   localparam logic [1:0] IO_RSV54_VALUE = 2'h1;
   localparam logic [1:0] IO_RSV32_VALUE = 2'h2;

   // converter mode encodings
   localparam logic [1:0] MODE_DISABLED = 2'h0;
   localparam logic [1:0] MODE_AUTO_A = 2'h1;
   localparam logic [1:0] MODE_AUTO_B = 2'h2;
   localparam logic [1:0] MODE_FORCED_PWM = 2'h3;

   // settling time the controller owes after leaving forced pwm, before decay
   localparam int CLK_PERIOD_NS = 50;
   localparam int PWM_EXIT_WAIT_NS = 2000;
   localparam int PWM_EXIT_WAIT_CYC = (PWM_EXIT_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // i2c framing
   localparam logic [3:0] I2C_BITS = 4'h8;
   localparam int PIN_W = 9;

   // synchronised pin bundle
   typedef struct packed {
      logic scl;
      logic sda;
      logic sleep_n;
      logic [3:0] rail_good;
      logic io_good;
      logic tree_other;
   } pgr_pins_t;

   localparam pgr_pins_t PINS_IDLE = '{scl: 1'b1, sda: 1'b1, sleep_n: 1'b1,
                                       rail_good: 4'h0, io_good: 1'b0, tree_other: 1'b0};

   typedef enum logic [3:0] {
      PH_IDLE, PH_ADDR, PH_ADDR_ACK, PH_PTR, PH_PTR_ACK,
      PH_WDATA, PH_WDATA_ACK, PH_RDATA, PH_RDATA_ACK
   } pgr_phase_t;

   typedef struct packed {
      pgr_phase_t ph;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic [7:0] ptr;
      logic rw;
      logic mack_n;
      logic scl_prev;
      logic sda_prev;
      logic sda_oe;
      logic sda_o;
      logic [3:0] mask;
      logic decay_en;
      logic [1:0] mode;
      logic pg_out;
      logic io_good_out;
      logic conv_en;
      logic pwm_forced;
      logic decay_out;
   } pgr_state_t;

endpackage : pgr_pkg

`default_nettype wire

// file: hw/pgr_sync.sv
// two-flop synchroniser for the pin inputs
`default_nettype none

module pgr_sync
   import pgr_pkg::*;
#(
   parameter int W = PIN_W,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic clk, // system clock
   input wire logic sys_rst, // synchronous reset, active high
   input wire logic [W-1:0] d, // asynchronous inputs
   output logic [W-1:0] q // synchronised copy
);

   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stab;
   } pgr_sync_t;

   pgr_sync_t st_q;
   pgr_sync_t st_d;

   // first stage feeds only the second stage
   always_comb begin
      st_d.meta = d;
      st_d.stab = st_q.meta;
      if (sys_rst) begin
         st_d.meta = RST_VAL;
         st_d.stab = RST_VAL;
      end
   end

   always_ff @(posedge clk) begin
      st_q <= st_d;
   end

   assign q = st_q.stab;

endmodule // pgr_sync

`default_nettype wire

// file: hw/pgr_ctrl.sv
// power-good tree mask and i/o rail control registers behind an i2c slave
//
// Summary of operation
// - upper mask at 0x19, resets to zero
// - mask 0 keeps input, 1 forces one
// - bit 3 masks dual low rail good
// - bit 2 masks memory rail good
// - bit 1 masks switched 3.3 V good
// - bit 0 masks switched 1.8 V good
// - i/o rail control at 0x30, reset 0x1a
// - bit 6 enables decay on sleep, resets 0
// - decay disabled holds rail regardless of sleep
// - decay on sleep low, keep good asserted
// - mode field 0 off, 1/2 auto, 3 pwm
`default_nettype none

module pgr_ctrl
   import pgr_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = 7'h2a // bus address, plain default
) (
   input wire logic clk, // system clock, 20 MHz
   input wire logic sys_rst, // main-domain synchronous reset
   input wire logic rtc_rst, // always-on domain synchronous reset
   input wire logic scl_i, // i2c clock pin level
   input wire logic sda_i, // i2c data pin level
   output logic sda_o, // i2c data drive value, always low
   output logic sda_oe, // i2c data pull-low enable
   input wire logic sleep_request_n, // sleep request, active low
   input wire logic [3:0] rail_good, // raw good inputs of the four masked rails
   input wire logic io_rail_good, // raw good of the i/o rail
   input wire logic tree_other_good, // rest of the good tree, already masked
   output logic power_good_indication, // combined good tree output
   output logic io_rail_good_ind, // i/o rail good as seen by the tree
   output logic io_rail_conv_en, // i/o rail converter enabled
   output logic forced_pwm_mode, // i/o rail in forced pwm
   output logic io_rail_decay, // i/o rail decaying to 0 V
   output logic [1:0] io_rail_mode_select // i/o rail mode field as stored
);

   pgr_pins_t pin_raw;
   pgr_pins_t pin_s;
   pgr_state_t st_q;
   pgr_state_t st_d;

   logic scl_rise;
   logic scl_fall;
   logic start_cond;
   logic stop_cond;
   logic decay_now;
   logic io_good_eff;
   logic [3:0] tree_masked;

   // register read image; unmapped offsets read zero
   // reserved bits fixed
   function automatic logic [7:0] rd_data(input logic [7:0] ptr, input logic [3:0] mask,
                                          input logic dec, input logic [1:0] mode);
      logic [7:0] r;
      r = 8'h00;
      if (ptr == OFS_PG_MASK_UPPER) begin
         r = {MASK_RSV_VALUE, mask};
      end else if (ptr == OFS_IO_RAIL_CTRL) begin
         r = {IO_RSV7_VALUE, dec, IO_RSV54_VALUE, IO_RSV32_VALUE, mode};
      end
      return r;
   endfunction

   assign pin_raw = '{scl: scl_i, sda: sda_i, sleep_n: sleep_request_n,
                      rail_good: rail_good, io_good: io_rail_good, tree_other: tree_other_good};

   pgr_sync #(
      .W(PIN_W),
      .RST_VAL(PINS_IDLE)
   ) u_sync (
      .clk(clk),
      .sys_rst(sys_rst),
      .d(pin_raw),
      .q(pin_s)
   );

   assign scl_rise = pin_s.scl & ~st_q.scl_prev;
   assign scl_fall = ~pin_s.scl & st_q.scl_prev;
   assign start_cond = pin_s.scl & st_q.sda_prev & ~pin_s.sda;
   assign stop_cond = pin_s.scl & ~st_q.sda_prev & pin_s.sda;

   // decay only when enabled and sleep low
   assign decay_now = st_q.decay_en & ~pin_s.sleep_n;
   assign io_good_eff = pin_s.io_good | decay_now;

   always_comb begin
      tree_masked = '0;
      tree_masked[POS_MASK_DUAL_LOW_RAIL] = pin_s.rail_good[POS_MASK_DUAL_LOW_RAIL] |
                                            st_q.mask[POS_MASK_DUAL_LOW_RAIL];
      tree_masked[POS_MASK_MEMORY_RAIL] = pin_s.rail_good[POS_MASK_MEMORY_RAIL] |
                                          st_q.mask[POS_MASK_MEMORY_RAIL];
      tree_masked[POS_MASK_SWITCHED_3V3] = pin_s.rail_good[POS_MASK_SWITCHED_3V3] |
                                           st_q.mask[POS_MASK_SWITCHED_3V3];
      tree_masked[POS_MASK_SWITCHED_1V8] = pin_s.rail_good[POS_MASK_SWITCHED_1V8] |
                                           st_q.mask[POS_MASK_SWITCHED_1V8];
   end

   always_comb begin
      st_d = st_q;
      st_d.scl_prev = pin_s.scl;
      st_d.sda_prev = pin_s.sda;
      st_d.sda_o = 1'b0;

      case (st_q.ph)
         PH_IDLE: begin
            st_d.sda_oe = 1'b0;
         end
         PH_ADDR, PH_PTR, PH_WDATA: begin
            if (scl_rise) begin
               st_d.sh = {st_q.sh[6:0], pin_s.sda};
               st_d.cnt = st_q.cnt + 4'h1;
            end
            if (scl_fall && st_q.cnt == I2C_BITS) begin
               st_d.cnt = '0;
               if (st_q.ph == PH_ADDR) begin
                  // a foreign address leaves the bus untouched until the next start
                  if (st_q.sh[7:1] == DEV_ADDR) begin
                     st_d.rw = st_q.sh[0];
                     st_d.sda_oe = 1'b1;
                     st_d.ph = PH_ADDR_ACK;
                  end else begin
                     st_d.ph = PH_IDLE;
                  end
               end else if (st_q.ph == PH_PTR) begin
                  st_d.ptr = st_q.sh;
                  st_d.sda_oe = 1'b1;
                  st_d.ph = PH_PTR_ACK;
               end else begin
                  if (st_q.ptr == OFS_PG_MASK_UPPER) begin
                     st_d.mask = st_q.sh[3:0];
                  end
                  if (st_q.ptr == OFS_IO_RAIL_CTRL) begin
                     st_d.decay_en = st_q.sh[POS_IO_DECAY_EN];
                     st_d.mode = st_q.sh[POS_IO_MODE_HI:POS_IO_MODE_LO];
                  end
                  st_d.ptr = st_q.ptr + 8'h01;
                  st_d.sda_oe = 1'b1;
                  st_d.ph = PH_WDATA_ACK;
               end
            end
         end
         PH_ADDR_ACK: begin
            if (scl_fall) begin
               if (st_q.rw) begin
                  st_d.sh = rd_data(st_q.ptr, st_q.mask, st_q.decay_en, st_q.mode);
                  st_d.sda_oe = ~st_d.sh[7];
                  st_d.cnt = '0;
                  st_d.ph = PH_RDATA;
               end else begin
                  st_d.sda_oe = 1'b0;
                  st_d.ph = PH_PTR;
               end
            end
         end
         PH_PTR_ACK, PH_WDATA_ACK: begin
            if (scl_fall) begin
               st_d.sda_oe = 1'b0;
               st_d.ph = PH_WDATA;
            end
         end
         PH_RDATA: begin
            if (scl_fall) begin
               if (st_q.cnt == I2C_BITS - 4'h1) begin
                  st_d.sda_oe = 1'b0;
                  st_d.cnt = '0;
                  st_d.ptr = st_q.ptr + 8'h01;
                  st_d.ph = PH_RDATA_ACK;
               end else begin
                  st_d.sh = {st_q.sh[6:0], 1'b0};
                  st_d.sda_oe = ~st_q.sh[6];
                  st_d.cnt = st_q.cnt + 4'h1;
               end
            end
         end
         PH_RDATA_ACK: begin
            if (scl_rise) begin
               st_d.mack_n = pin_s.sda;
            end
            if (scl_fall) begin
               // a not-acknowledge ends the read and frees the line
               if (st_q.mack_n) begin
                  st_d.ph = PH_IDLE;
               end else begin
                  st_d.sh = rd_data(st_q.ptr, st_q.mask, st_q.decay_en, st_q.mode);
                  st_d.sda_oe = ~st_d.sh[7];
                  st_d.ph = PH_RDATA;
               end
            end
         end
         default: begin
            st_d.ph = PH_IDLE;
            st_d.sda_oe = 1'b0;
         end
      endcase

      // a start or stop seen anywhere resynchronises the slave
      if (start_cond) begin
         st_d.ph = PH_ADDR;
         st_d.cnt = '0;
         st_d.sda_oe = 1'b0;
      end else if (stop_cond) begin
         st_d.ph = PH_IDLE;
         st_d.sda_oe = 1'b0;
      end

      st_d.pg_out = (&tree_masked) & io_good_eff & pin_s.tree_other;
      st_d.io_good_out = io_good_eff;
      st_d.conv_en = (st_q.mode != MODE_DISABLED);
      st_d.pwm_forced = (st_q.mode == MODE_FORCED_PWM);
      st_d.decay_out = decay_now;

      if (sys_rst) begin
         st_d.ph = PH_IDLE;
         st_d.cnt = '0;
         st_d.sh = '0;
         st_d.ptr = '0;
         st_d.rw = 1'b0;
         st_d.mack_n = 1'b1;
         st_d.scl_prev = 1'b1;
         st_d.sda_prev = 1'b1;
         st_d.sda_oe = 1'b0;
         st_d.sda_o = 1'b0;
         st_d.decay_en = RST_DECAY_EN;
         st_d.mode = RST_MODE;
         st_d.pg_out = 1'b0;
         st_d.io_good_out = 1'b0;
         st_d.conv_en = 1'b0;
         st_d.pwm_forced = 1'b0;
         st_d.decay_out = 1'b0;
      end
      // mask lives in the always-on domain, so only its own reset clears it
      if (rtc_rst) begin
         st_d.mask = RST_MASK_BITS;
      end
   end

   always_ff @(posedge clk) begin
      st_q <= st_d;
   end

   assign sda_o = st_q.sda_o;
   assign sda_oe = st_q.sda_oe;
   assign power_good_indication = st_q.pg_out;
   assign io_rail_good_ind = st_q.io_good_out;
   assign io_rail_conv_en = st_q.conv_en;
   assign forced_pwm_mode = st_q.pwm_forced;
   assign io_rail_decay = st_q.decay_out;
   assign io_rail_mode_select = st_q.mode;

endmodule // pgr_ctrl

`default_nettype wire

// file: bench/pgr_ctrl_asserts.sv
// port checks for the power-good mask and i/o rail block
`default_nettype none
module pgr_ctrl_asserts import pgr_pkg::*; (
   input wire logic clk, // clock
   input wire logic sys_rst, // main reset
   input wire logic rtc_rst, // mask reset
   input wire logic sda_oe, // ack drive
   input wire logic sleep_request_n, // sleep, low
   input wire logic [3:0] rail_good, // raw goods
   input wire logic io_rail_good, // i/o good
   input wire logic tree_other_good, // rest of tree
   input wire logic power_good_indication, // tree out
   input wire logic io_rail_good_ind, // i/o good out
   input wire logic io_rail_conv_en, // converter on
   input wire logic forced_pwm_mode, // pwm forced
   input wire logic io_rail_decay, // decaying
   input wire logic [1:0] io_rail_mode_select // mode
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0] up_q;
   logic warm;
   logic all_good;
   // the pin pipe holds reset values for three cycles after a main reset
   assign warm = up_q > 3'h3;
   assign all_good = &rail_good & io_rail_good & tree_other_good;
   always_ff @(posedge clk) begin
      if (sys_rst || rtc_rst) begin
         up_q <= 3'h0;
      end else if (up_q != 3'h7) begin
         up_q <= up_q + 3'h1;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst || rtc_rst);
   AST_DECAY_NEEDS_SLEEP:
      assert property (warm && io_rail_decay |-> !$past(sleep_request_n, 3)) else $error("decay while awake");
   AST_WAKE_ENDS_DECAY:
      assert property ($rose(sleep_request_n) |-> ##3 !io_rail_decay) else $error("decay after wake");
   AST_GOOD_HELD_IN_DECAY:
      assert property (io_rail_decay && $past(io_rail_decay) |-> io_rail_good_ind) else $error("good lost in decay");
   AST_GOOD_FOLLOWS_RAIL:
      assert property (warm && !io_rail_decay && !$past(io_rail_decay) |-> io_rail_good_ind == $past(io_rail_good, 3))
         else $error("i/o good wrong");
   AST_REST_LOW:
      assert property (warm && !$past(tree_other_good, 3) |-> !power_good_indication) else $error("tree good high");
   AST_ALL_GOOD:
      assert property (warm && $past(all_good, 3) |-> power_good_indication) else $error("tree good low");
   AST_IO_LOW_DROPS:
      assert property (warm && !io_rail_decay && !$past(io_rail_decay) && !$past(io_rail_good, 3)
         |-> !power_good_indication) else $error("i/o low not in tree");
   AST_CONV_DECODE:
      assert property (warm && $stable(io_rail_mode_select) |-> io_rail_conv_en == (io_rail_mode_select != MODE_DISABLED))
         else $error("converter enable wrong");
   AST_PWM_DECODE:
      assert property (warm && $stable(io_rail_mode_select)
         |-> forced_pwm_mode == (io_rail_mode_select == MODE_FORCED_PWM)) else $error("forced pwm wrong");
   AST_RESET_MODE:
      assert property ($fell(sys_rst) |-> io_rail_mode_select == RST_MODE && !io_rail_decay) else $error("reset mode");
   cover property (io_rail_decay);
   cover property ($rose(power_good_indication));
   cover property (forced_pwm_mode);
   cover property ($rose(sda_oe));
endmodule // pgr_ctrl_asserts
bind pgr_ctrl pgr_ctrl_asserts u_chk (.clk, .sys_rst, .rtc_rst, .sda_oe, .sleep_request_n, .rail_good, .io_rail_good,
   .tree_other_good, .power_good_indication, .io_rail_good_ind, .io_rail_conv_en, .forced_pwm_mode, .io_rail_decay,
   .io_rail_mode_select);
`default_nettype wire

// file: bench/pgr_ec_model.sv
// embedded-controller model: i2c master reaching the block's registers
`default_nettype none
module pgr_ec_model (
   input wire logic clk, // clock
   input wire logic sda_oe, // device pulls low
   input wire logic sda_o, // device level
   output logic scl, // bus clock
   output logic sda // data wire
);
   timeunit 1ns;
   timeprecision 1ns;
   logic sda_m = 1'b1;
   // open drain with pull-up: a released line reads high
   assign sda = sda_m & ~(sda_oe & ~sda_o);
   initial scl = 1'b1;
   // six cycles a phase, above the three the sampler needs; one pin moves per step
   task automatic step(input logic c, input logic d);
      scl = c;
      sda_m = d;
      repeat (6) @(negedge clk);
   endtask
   task automatic start();
      step(1'b0, 1'b1);
      step(1'b1, 1'b1);
      step(1'b1, 1'b0);
      step(1'b0, 1'b0);
   endtask
   task automatic stop();
      step(1'b0, 1'b0);
      step(1'b1, 1'b0);
      step(1'b1, 1'b1);
   endtask
   task automatic bitx(input logic b, output logic r);
      step(1'b0, b);
      step(1'b1, b);
      r = sda;
      step(1'b0, b);
   endtask
   task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] q, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bitx(d[i], r);
         q[i] = r;
      end
      bitx(mack, r);
      ack = ~r;
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d, output logic ok);
      logic [7:0] q;
      logic k1, k2, k3;
      start();
      xfer({a, 1'b0}, 1'b1, q, k1);
      xfer(p, 1'b1, q, k2);
      xfer(d, 1'b1, q, k3);
      stop();
      ok = k1 & k2 & k3;
   endtask
   // pointer write, repeated start, one byte closed by a nack
   task automatic rd(input logic [6:0] a, input logic [7:0] p, output logic [7:0] d);
      logic [7:0] q;
      logic k;
      start();
      xfer({a, 1'b0}, 1'b1, q, k);
      xfer(p, 1'b1, q, k);
      start();
      xfer({a, 1'b1}, 1'b1, q, k);
      xfer(8'hff, 1'b1, d, k);
      stop();
   endtask
   // two-byte read: the master acknowledge keeps the slave going at the next offset
   task automatic rd2(input logic [6:0] a, input logic [7:0] p, output logic [15:0] d);
      logic [7:0] q;
      logic k;
      start();
      xfer({a, 1'b0}, 1'b1, q, k);
      xfer(p, 1'b1, q, k);
      start();
      xfer({a, 1'b1}, 1'b1, q, k);
      xfer(8'hff, 1'b0, d[15:8], k);
      xfer(8'hff, 1'b1, d[7:0], k);
      stop();
   endtask
endmodule // pgr_ec_model
`default_nettype wire

// file: bench/pgr_ctrl_test.sv
// self-checking bench for the power-good mask and i/o rail block
`default_nettype none
module pgr_ctrl_test import pgr_pkg::*; ();
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [6:0] ADR = 7'h2a;
   logic clk, sys_rst, rtc_rst, scl, sda, sda_o, sda_oe, sleep_request_n, io_rail_good, tree_other_good, ok;
   logic power_good_indication, io_rail_good_ind, io_rail_conv_en, forced_pwm_mode, io_rail_decay;
   logic [3:0] rail_good;
   logic [1:0] io_rail_mode_select;
   logic [7:0] rv;
   logic [15:0] rv2;
   int fail_count = 0;
   int samples_checked = 0;
   // mask, raw rail goods, i/o good, rest of tree, expected tree output
   logic [10:0] rows [10] = '{
      {4'h0, 4'hf, 3'h7},
      {4'h0, 4'he, 3'h6},
      {4'h1, 4'he, 3'h7},
      {4'h2, 4'hd, 3'h7},
      {4'h4, 4'hb, 3'h7},
      {4'h8, 4'h7, 3'h7},
      {4'h7, 4'h7, 3'h6},
      {4'hf, 4'h0, 3'h7},
      {4'hf, 4'h0, 3'h4},
      {4'hf, 4'h0, 3'h2}
   };
   pgr_ctrl #(.DEV_ADDR(ADR)) u_dut (.clk, .sys_rst, .rtc_rst, .scl_i(scl), .sda_i(sda), .sda_o, .sda_oe,
      .sleep_request_n, .rail_good, .io_rail_good, .tree_other_good, .power_good_indication, .io_rail_good_ind,
      .io_rail_conv_en, .forced_pwm_mode, .io_rail_decay, .io_rail_mode_select);
   pgr_ec_model u_ec (.clk, .sda_oe, .sda_o, .scl, .sda);
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic ck(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t: got %h, want %h", $time, got, exp);
      end
   endtask
   task automatic final_report();
      if (fail_count == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // about twice the expected run, so a stuck bus ends the test
   initial begin
      repeat (40000) @(posedge clk);
      fail_count++;
      final_report();
   end
   initial begin
      sys_rst = 1'b1;
      rtc_rst = 1'b1;
      sleep_request_n = 1'b1;
      {rail_good, io_rail_good, tree_other_good} = 6'h3f;
      repeat (4) @(negedge clk);
      sys_rst = 1'b0;
      rtc_rst = 1'b0;
      repeat (4) @(negedge clk);
      for (int i = 0; i < 10; i++) begin
         u_ec.wr(ADR, OFS_PG_MASK_UPPER, {4'ha, rows[i][10:7]}, ok);
         ck(8'(ok), 8'h01);
         {rail_good, io_rail_good, tree_other_good} = rows[i][6:1];
         repeat (5) @(negedge clk);
         ck(8'(power_good_indication), 8'(rows[i][0]));
         u_ec.rd(ADR, OFS_PG_MASK_UPPER, rv);
         ck(rv, {4'h0, rows[i][10:7]});
      end
      for (int m = 0; m < 4; m++) begin
         u_ec.wr(ADR, OFS_IO_RAIL_CTRL, 8'(m), ok);
         repeat (3) @(negedge clk);
         ck({4'h0, io_rail_conv_en, forced_pwm_mode, io_rail_mode_select}, {4'h0, m != 0, m == 3, 2'(m)});
      end
      sleep_request_n = 1'b0;
      repeat (5) @(negedge clk);
      ck(8'({io_rail_decay, io_rail_good_ind}), 8'h00);
      sleep_request_n = 1'b1;
      u_ec.wr(ADR, OFS_IO_RAIL_CTRL, 8'hff, ok);
      u_ec.rd(ADR, OFS_IO_RAIL_CTRL, rv);
      ck(rv, 8'h5b);
      u_ec.wr(ADR, OFS_IO_RAIL_CTRL, 8'h42, ok);
      repeat (PWM_EXIT_WAIT_CYC) @(negedge clk);
      sleep_request_n = 1'b0;
      repeat (5) @(negedge clk);
      ck(8'({io_rail_decay, io_rail_good_ind, power_good_indication}), 8'h07);
      sleep_request_n = 1'b1;
      repeat (5) @(negedge clk);
      ck(8'({io_rail_decay, io_rail_good_ind, power_good_indication}), 8'h00);
      u_ec.wr(ADR ^ 7'h01, OFS_IO_RAIL_CTRL, 8'h00, ok);
      ck(8'(ok), 8'h00);
      u_ec.rd(ADR, OFS_IO_RAIL_CTRL, rv);
      ck(rv, 8'h5a);
      u_ec.rd(ADR, 8'h20, rv);
      ck(rv, 8'h00);
      sys_rst = 1'b1;
      repeat (4) @(negedge clk);
      sys_rst = 1'b0;
      repeat (4) @(negedge clk);
      u_ec.rd(ADR, OFS_IO_RAIL_CTRL, rv);
      ck(rv, RST_IO_RAIL_CTRL);
      // unmapped offset below the rail register, then the pointer steps onto it
      u_ec.rd2(ADR, OFS_IO_RAIL_CTRL - 8'h01, rv2);
      ck(rv2[15:8], 8'h00);
      ck(rv2[7:0], RST_IO_RAIL_CTRL);
      u_ec.rd(ADR, OFS_PG_MASK_UPPER, rv);
      ck(rv, 8'h0f);
      rtc_rst = 1'b1;
      @(negedge clk);
      rtc_rst = 1'b0;
      u_ec.rd(ADR, OFS_PG_MASK_UPPER, rv);
      ck(rv, RST_PG_MASK_UPPER);
      final_report();
   end
endmodule // pgr_ctrl_test
`default_nettype wire
